// >>> odc_pkg.sv
// Purpose: Shared constants and carriers for the output divider bank
// Assumes: Byte-wide registers on a simple synchronous register port
// Notes: Register index is address minus ODC_BASE_OFFSET
package odc_pkg;
    localparam int ODC_BYTE_W = 8;
    localparam int ODC_DIV_W = 20;
    localparam int ODC_NUM_OUT = 5;
    localparam int ODC_NUM_REGS = 14;
    localparam int ODC_NIB_W = 4;

    // Register offsets
    localparam logic [7:0] ODC_OUT1_MID_OFF = 8'h1a;
    localparam logic [7:0] ODC_OUT1_LOW_OFF = 8'h1b;
    localparam logic [7:0] ODC_OUT2_HI_OFF = 8'h1c;
    localparam logic [7:0] ODC_OUT2_MID_OFF = 8'h1d;
    localparam logic [7:0] ODC_OUT2_LOW_OFF = 8'h1e;
    localparam logic [7:0] ODC_OUT3_HI_OFF = 8'h1f;
    localparam logic [7:0] ODC_OUT3_MID_OFF = 8'h20;
    localparam logic [7:0] ODC_OUT3_LOW_OFF = 8'h21;
    localparam logic [7:0] ODC_OUT4_HI_OFF = 8'h22;
    localparam logic [7:0] ODC_OUT4_MID_OFF = 8'h23;
    localparam logic [7:0] ODC_OUT4_LOW_OFF = 8'h24;
    localparam logic [7:0] ODC_OUT5_HI_OFF = 8'h25;
    localparam logic [7:0] ODC_OUT5_MID_OFF = 8'h26;
    localparam logic [7:0] ODC_OUT5_LOW_OFF = 8'h27;
    localparam logic [7:0] ODC_BASE_OFFSET = ODC_OUT1_MID_OFF;

    // Reset values
    localparam logic [7:0] ODC_LOW_RST = 8'h31;
    localparam logic [7:0] ODC_MID_RST = 8'h00;
    localparam logic [7:0] ODC_HI_RST = 8'h00;

    // Writable bit masks; high nibble registers keep bits 7:4 reserved
    localparam logic [7:0] ODC_HI_MASK = 8'h0f;
    localparam logic [7:0] ODC_FULL_MASK = 8'hff;

    // Clock configuration value under which output 5 encoding holds
    localparam logic ODC_CFG_DIRECT = 1'b0;

    // Per-index tables, index 0 at the lowest offset
    localparam logic [ODC_NUM_REGS-1:0][7:0] ODC_RESET_TABLE = {
        ODC_LOW_RST, ODC_MID_RST, ODC_HI_RST,
        ODC_LOW_RST, ODC_MID_RST, ODC_HI_RST,
        ODC_LOW_RST, ODC_MID_RST, ODC_HI_RST,
        ODC_LOW_RST, ODC_MID_RST, ODC_HI_RST,
        ODC_LOW_RST, ODC_MID_RST};
    localparam logic [ODC_NUM_REGS-1:0][7:0] ODC_MASK_TABLE = {
        ODC_FULL_MASK, ODC_FULL_MASK, ODC_HI_MASK,
        ODC_FULL_MASK, ODC_FULL_MASK, ODC_HI_MASK,
        ODC_FULL_MASK, ODC_FULL_MASK, ODC_HI_MASK,
        ODC_FULL_MASK, ODC_FULL_MASK, ODC_HI_MASK,
        ODC_FULL_MASK, ODC_FULL_MASK};

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } odc_req_s;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic hit;
    } odc_rsp_s;

    typedef logic [ODC_NUM_OUT-1:0][ODC_DIV_W-1:0] odc_div_t;
endpackage

// >>> odc_byte_cell.sv
// Purpose: One byte-wide divider register with reserved-bit masking
// Assumes: Synchronous active-high reset, clock enable freezes state
// Notes: Reserved bits are held at zero and never written
`timescale 1ns/100ps
module odc_byte_cell #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] value_o
);
    import odc_pkg::*;

    typedef struct packed {
        logic [7:0] value;
    } odc_cell_s;

    odc_cell_s state_reg;
    odc_cell_s state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_en_i) begin
            state_next.value = wdata_i & WR_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg.value <= RESET_VAL & WR_MASK;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    assign value_o = state_reg.value;
endmodule

// >>> odc_divider_regs.sv
// Purpose: Output low-speed divider register bank, outputs 1 to 5
// Assumes: Register port is synchronous to clk_sys_i
// Notes: Read data return one cycle after the read strobe
//
// Summary of operation
// - Output 2 divider, nibble in bits 3:0
// - Output 3 divider across three registers
// - Output 4 divider across three registers
// - Output 5 divider, reserved upper nibble bits
// - Output 5 encoding valid only at config zero
// - Low divider bytes reset to 0x31
// - Listed middle and high bytes reset zero
// - Output 1 divider also zero or odd
`timescale 1ns/100ps
module odc_divider_regs (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input odc_pkg::odc_req_s reg_req_i,
    input wire logic [3:0] out1_high_nibble_i,
    input wire logic clock_configuration_select_i,
    output odc_pkg::odc_rsp_s reg_rsp_o,
    output odc_pkg::odc_div_t low_speed_divider_o,
    output logic [4:0] divider_legal_o,
    output logic out5_encoding_valid_o
);
    import odc_pkg::*;

    typedef struct packed {
        odc_rsp_s rsp;
        odc_div_t div;
        logic [ODC_NUM_OUT-1:0] legal;
        logic out5_valid;
    } odc_state_s;

    odc_state_s state_reg;
    odc_state_s state_next;

    logic [ODC_NUM_REGS-1:0][7:0] cell_q;
    logic [7:0] idx;
    logic hit;
    odc_div_t div_asm;

    // Address decode
    always_comb begin
        idx = reg_req_i.addr - ODC_BASE_OFFSET;
        hit = (reg_req_i.addr >= ODC_BASE_OFFSET) &&
              (idx < 8'(ODC_NUM_REGS));
    end

    // Byte registers
    genvar g;
    generate
        for (g = 0; g < ODC_NUM_REGS; g = g + 1) begin : gen_cell
            odc_byte_cell #(
                .RESET_VAL(ODC_RESET_TABLE[g]),
                .WR_MASK(ODC_MASK_TABLE[g])
            ) u_cell (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .clk_en_i(clk_en_i),
                .wr_en_i(reg_req_i.wr && hit && (idx == 8'(g))),
                .wdata_i(reg_req_i.wdata),
                .value_o(cell_q[g])
            );
        end
    endgenerate

    // Assemble 20-bit dividers from nibble, middle and low bytes
    always_comb begin
        div_asm[0] = {out1_high_nibble_i, cell_q[0], cell_q[1]};
        for (int k = 1; k < ODC_NUM_OUT; k++) begin
            div_asm[k] = {cell_q[3*k-1][ODC_NIB_W-1:0],
                          cell_q[3*k], cell_q[3*k+1]};
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.rsp.rvalid = reg_req_i.rd;
        state_next.rsp.hit = reg_req_i.rd && hit;
        if (reg_req_i.rd) begin
            state_next.rsp.rdata = hit ? cell_q[idx[3:0]] : 8'h00;
        end
        state_next.div = div_asm;
        for (int k = 0; k < ODC_NUM_OUT; k++) begin
            state_next.legal[k] = (div_asm[k] == 20'h00000) ||
                                  div_asm[k][0];
        end
        state_next.out5_valid =
            (clock_configuration_select_i == ODC_CFG_DIRECT);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    assign reg_rsp_o = state_reg.rsp;
    assign low_speed_divider_o = state_reg.div;
    assign divider_legal_o = state_reg.legal;
    assign out5_encoding_valid_o = state_reg.out5_valid;

    // Checks
    sequence wr_seq(logic [7:0] a);
        clk_en_i && reg_req_i.wr && reg_req_i.addr == a;
    endsequence

    sequence quiet_seq;
        clk_en_i && !reg_req_i.wr;
    endsequence

    sequence rd_seq(logic [7:0] a);
        clk_en_i && reg_req_i.rd && reg_req_i.addr == a;
    endsequence

    low_reset_a: assert property (@(posedge clk_sys_i)
        $fell(sys_rst_i) |-> cell_q[1] == ODC_LOW_RST &&
        cell_q[4] == ODC_LOW_RST && cell_q[7] == ODC_LOW_RST &&
        cell_q[10] == ODC_LOW_RST)
        else $error("low divider byte reset value wrong");

    zero_reset_a: assert property (@(posedge clk_sys_i)
        $fell(sys_rst_i) |-> cell_q[3] == 8'h00 &&
        cell_q[9] == 8'h00 && cell_q[5] == 8'h00 && cell_q[11] == 8'h00)
        else $error("middle or high byte reset value wrong");

    readback_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT3_MID_OFF) ##1 quiet_seq ##1
        (rd_seq(ODC_OUT3_MID_OFF) and quiet_seq) ##1 clk_en_i |->
        reg_rsp_o.rdata == $past(reg_req_i.wdata, 3))
        else $error("register read back differs from write");

    out2_nibble_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        rd_seq(ODC_OUT2_HI_OFF) ##1 clk_en_i |->
        reg_rsp_o.hit && reg_rsp_o.rdata[7:4] == 4'h0)
        else $error("reserved bits of output 2 nibble not zero");

    out5_nibble_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT5_HI_OFF) ##1 quiet_seq ##1 clk_en_i |->
        low_speed_divider_o[4][19:16] == $past(reg_req_i.wdata[3:0], 2) &&
        cell_q[11][7:4] == 4'h0)
        else $error("output 5 nibble not stored in low four bits");

    out3_asm_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i ##1 clk_en_i |-> low_speed_divider_o[2] ==
        $past({cell_q[5][3:0], cell_q[6], cell_q[7]}))
        else $error("output 3 divider assembly wrong");

    out4_asm_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT4_LOW_OFF) ##1 quiet_seq ##1 clk_en_i |->
        low_speed_divider_o[3][7:0] == $past(reg_req_i.wdata, 2))
        else $error("output 4 low byte not reflected in divider");

    cfg_gate_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i ##1 clk_en_i |-> out5_encoding_valid_o ==
        ($past(clock_configuration_select_i) == ODC_CFG_DIRECT))
        else $error("output 5 encoding valid flag wrong");

    out1_legal_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i ##1 clk_en_i |-> divider_legal_o[0] ==
        ($past(div_asm[0]) == 20'h00000 || $past(div_asm[0][0])))
        else $error("output 1 legality flag wrong");

    unmapped_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && reg_req_i.rd && !hit ##1 clk_en_i |->
        reg_rsp_o.rvalid && !reg_rsp_o.hit && reg_rsp_o.rdata == 8'h00)
        else $error("unmapped read not answered with zero");

    rd_answer_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && reg_req_i.rd |=> reg_rsp_o.rvalid)
        else $error("read not answered after one cycle");

    idle_answer_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && !reg_req_i.rd |=>
        !reg_rsp_o.rvalid && !reg_rsp_o.hit)
        else $error("read answer without a read");

    rdata_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && !reg_req_i.rd |=> $stable(reg_rsp_o.rdata))
        else $error("read data changed without a read");

    mapped_hit_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && reg_req_i.rd && hit |=> reg_rsp_o.hit)
        else $error("mapped read not flagged as hit");

    cell_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && !reg_req_i.wr |=> $stable(cell_q))
        else $error("register changed without a write");

    stray_write_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && reg_req_i.wr && !hit |=> $stable(cell_q))
        else $error("unmapped write changed a register");

    freeze_cells_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        !clk_en_i |=> $stable(cell_q))
        else $error("register changed while clock enable low");

    freeze_outputs_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        !clk_en_i |=> $stable(reg_rsp_o) &&
        $stable(low_speed_divider_o) && $stable(divider_legal_o) &&
        $stable(out5_encoding_valid_o))
        else $error("output changed while clock enable low");

    reset_outputs_a: assert property (@(posedge clk_sys_i)
        sys_rst_i |=> reg_rsp_o == '0 && low_speed_divider_o == '0 &&
        divider_legal_o == '0 && !out5_encoding_valid_o)
        else $error("outputs not cleared by reset");

    out1_asm_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> low_speed_divider_o[0] ==
        $past({out1_high_nibble_i, cell_q[0], cell_q[1]}))
        else $error("output 1 divider assembly wrong");

    out2_asm_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> low_speed_divider_o[1] ==
        $past({cell_q[2][3:0], cell_q[3], cell_q[4]}))
        else $error("output 2 divider assembly wrong");

    out4_value_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> low_speed_divider_o[3] ==
        $past({cell_q[8][3:0], cell_q[9], cell_q[10]}))
        else $error("output 4 divider assembly wrong");

    out5_asm_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> low_speed_divider_o[4] ==
        $past({cell_q[11][3:0], cell_q[12], cell_q[13]}))
        else $error("output 5 divider assembly wrong");

    out2_rsvd_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        cell_q[2][7:4] == 4'h0)
        else $error("reserved bits of output 2 nibble set");

    out5_rsvd_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        cell_q[11][7:4] == 4'h0)
        else $error("reserved bits of output 5 nibble set");

    legal_out2_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> divider_legal_o[1] ==
        (low_speed_divider_o[1] == 20'h00000 || low_speed_divider_o[1][0]))
        else $error("output 2 legality flag wrong");

    legal_out3_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> divider_legal_o[2] ==
        (low_speed_divider_o[2] == 20'h00000 || low_speed_divider_o[2][0]))
        else $error("output 3 legality flag wrong");

    legal_out4_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> divider_legal_o[3] ==
        (low_speed_divider_o[3] == 20'h00000 || low_speed_divider_o[3][0]))
        else $error("output 4 legality flag wrong");

    legal_out5_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i |=> divider_legal_o[4] ==
        (low_speed_divider_o[4] == 20'h00000 || low_speed_divider_o[4][0]))
        else $error("output 5 legality flag wrong");

    out1_low_wr_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT1_LOW_OFF) |=> cell_q[1] == $past(reg_req_i.wdata))
        else $error("output 1 low byte write lost");

    out2_mid_wr_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT2_MID_OFF) |=> cell_q[3] == $past(reg_req_i.wdata))
        else $error("output 2 middle byte write lost");

    out3_hi_wr_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT3_HI_OFF) |=>
        cell_q[5] == ($past(reg_req_i.wdata) & ODC_HI_MASK))
        else $error("output 3 nibble write lost");

    out4_hi_wr_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_seq(ODC_OUT4_HI_OFF) |=>
        cell_q[8] == ($past(reg_req_i.wdata) & ODC_HI_MASK))
        else $error("output 4 nibble write lost");

    cfg_off_a: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        clk_en_i && clock_configuration_select_i != ODC_CFG_DIRECT |=>
        !out5_encoding_valid_o)
        else $error("output 5 encoding valid at nonzero config");
endmodule

// >>> odc_host_model.sv
// Purpose: Host model driving the divider bank register port
// Assumes: Requests launched 1 ns after a rising edge
// Notes: Released bus lines show the inverse of their last value
`timescale 1ns/100ps
module odc_host_model (
    input wire logic clk_sys_i,
    input odc_pkg::odc_rsp_s reg_rsp_i,
    output odc_pkg::odc_req_s reg_req_o
);
    import odc_pkg::*;
    initial reg_req_o = '0;
    // Callers hand in zero or odd divider bytes unless a test asks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_req_o.addr = a;
        reg_req_o.wdata = d;
        reg_req_o.wr = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_req_o.wr = 1'b0;
        reg_req_o.wdata = ~d;
        reg_req_o.addr = ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v, output logic h);
        @(posedge clk_sys_i);
        #1;
        reg_req_o.addr = a;
        reg_req_o.rd = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_req_o.rd = 1'b0;
        reg_req_o.addr = ~a;
        d = reg_rsp_i.rdata;
        v = reg_rsp_i.rvalid;
        h = reg_rsp_i.hit;
    endtask
endmodule

// >>> odc_divider_regs_tb.sv
// Purpose: Self-checking bench for the output divider bank
// Assumes: 250 MHz clock, synchronous active-high reset
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module odc_divider_regs_tb;
    import odc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic cfg_sel = 1'b0;
    logic [3:0] nib = 4'h0;
    odc_req_s req;
    odc_rsp_s rsp;
    odc_div_t div;
    logic [4:0] legal;
    logic enc_ok;
    logic [7:0] d;
    logic v, h;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    odc_host_model u_odc_host_model (.clk_sys_i(clk_sys_i),
        .reg_rsp_i(rsp), .reg_req_o(req));
    odc_divider_regs u_odc_divider_regs (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .reg_req_i(req),
        .out1_high_nibble_i(nib), .clock_configuration_select_i(cfg_sel),
        .reg_rsp_o(rsp), .low_speed_divider_o(div),
        .divider_legal_o(legal), .out5_encoding_valid_o(enc_ok));
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    function automatic logic [7:0] wmask(input logic [7:0] a);
        return (a == 8'h1c || a == 8'h1f || a == 8'h22 || a == 8'h25) ?
            8'h0f : 8'hff;
    endfunction
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        return (a == 8'h1b || a == 8'h1e || a == 8'h21 || a == 8'h24 ||
            a == 8'h27) ? 8'h31 : 8'h00;
    endfunction
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic t_reset();
        for (int i = 8'h1a; i <= 8'h27; i++) begin
            u_odc_host_model.rd(8'(i), d, v, h);
            chk(v & h & (d === rst_val(8'(i))), "rst");
        end
        chk(legal === 5'h1f, "rst legal");
        chk(div[1] === 20'h00031, "rst out2");
    endtask
    task automatic t_rw();
        for (int i = 8'h1a; i <= 8'h27; i++) begin
            u_odc_host_model.wr(8'(i), 8'hf5);
            u_odc_host_model.rd(8'(i), d, v, h);
            chk(d === (8'hf5 & wmask(8'(i))), "readback");
        end
        u_odc_host_model.rd(8'h30, d, v, h);
        chk(v === 1'b1 && h === 1'b0 && d === 8'h00, "unmapped");
        u_odc_host_model.wr(8'h28, 8'h00);
        u_odc_host_model.wr(8'h19, 8'h00);
        u_odc_host_model.rd(8'h27, d, v, h);
        chk(d === 8'hf5, "write above map");
        u_odc_host_model.rd(8'h1a, d, v, h);
        chk(d === 8'hf5, "write below map");
    endtask
    task automatic t_div();
        u_odc_host_model.wr(8'h1f, 8'h03);
        u_odc_host_model.wr(8'h20, 8'h45);
        u_odc_host_model.wr(8'h21, 8'h67);
        u_odc_host_model.wr(8'h24, 8'h66);
        settle();
        chk(div[2] === 20'h34567, "out3 value");
        chk(div[3] === 20'h5f566 && legal[3] === 1'b0, "out4 even");
        chk(div[4] === 20'h5f5f5 && legal[4] === 1'b1, "out5");
        u_odc_host_model.wr(8'h1c, 8'h00);
        u_odc_host_model.wr(8'h1d, 8'h00);
        u_odc_host_model.wr(8'h1e, 8'h00);
        settle();
        chk(div[1] === 20'h00000 && legal[1] === 1'b1, "out2 zero");
        u_odc_host_model.wr(8'h1e, 8'h02);
        settle();
        chk(div[1] === 20'h00002 && legal[1] === 1'b0, "out2 even");
    endtask
    task automatic t_cfg();
        cfg_sel = 1'b1;
        settle();
        chk(enc_ok === 1'b0, "cfg one");
        cfg_sel = 1'b0;
        nib = 4'h9;
        settle();
        chk(enc_ok === 1'b1, "cfg zero");
        chk(div[0] === 20'h9f5f5 && legal[0] === 1'b1, "out1");
    endtask
    task automatic t_freeze();
        @(posedge clk_sys_i);
        #1;
        clk_en_i = 1'b0;
        u_odc_host_model.wr(8'h26, 8'h11);
        clk_en_i = 1'b1;
        u_odc_host_model.rd(8'h26, d, v, h);
        chk(d === 8'hf5, "frozen write");
    endtask
    task automatic t_rerst();
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        u_odc_host_model.rd(8'h1b, d, v, h);
        chk(d === 8'h31, "rerst low");
        u_odc_host_model.rd(8'h1f, d, v, h);
        chk(d === 8'h00, "rerst high");
        chk(div[2] === 20'h00031, "rerst out3");
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_rw();
        t_div();
        t_cfg();
        t_freeze();
        t_rerst();
        wrap_up();
    end
endmodule
